/* verilog/lwc_top.sv */
// module: contender strap capture and link wake output with ahb-lite registers
`default_nettype none
module lwc_top (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// link side
	input wire logic link_power_status,
	input wire logic link_on_packet_rx,
	input wire logic bus_reset,
	input wire lwc_pkg::lwc_irq_ev_t irq_events,
	// shared strap and wake pin
	input wire logic contender_strap_wake_pin_in,
	output logic contender_strap_wake_pin_out,
	output logic contender_strap_wake_pin_oe,
	output logic contender_default
);
	logic pwr_sync;
	logic pin_sync;
	lwc_pkg::lwc_state_t state;
	lwc_pkg::lwc_state_t next_state;
	logic [2:0] settle_cnt;
	logic [2:0] next_settle_cnt;
	logic next_contender_default;
	logic [5:0] pwr_low_cnt;
	logic [5:0] next_pwr_low_cnt;
	logic pwr_active;
	logic link_idle;
	logic irq_cond;
	logic linkon_pending;
	logic next_linkon_pending;
	logic wake_active;
	logic next_wake_active;
	logic [1:0] phase_cnt;
	logic [1:0] next_phase_cnt;
	logic wave;
	logic next_wave;
	logic [1:0] ctrl;
	logic [1:0] next_ctrl;
	logic [3:0] irq_stat;
	logic [3:0] next_irq_stat;
	logic dp_write;
	logic next_dp_write;
	logic [3:0] dp_addr;
	logic [3:0] next_dp_addr;
	logic [31:0] next_hrdata;
	logic addr_phase;
	logic [31:0] stat_word;

	// both outside inputs pass the three-stage chain
	lwc_sync3 #(
		.WIDTH(2)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.ce(ce),
		.async_in({link_power_status, contender_strap_wake_pin_in}),
		.sync_out({pwr_sync, pin_sync})
	);

	// strap capture once the chain has settled after release
	always_comb begin
		next_state = state;
		next_settle_cnt = settle_cnt;
		next_contender_default = contender_default;
		case (state)
			lwc_pkg::LWC_ST_SETTLE: begin
				if (settle_cnt == lwc_pkg::STRAP_SETTLE) begin
					next_contender_default = pin_sync;
					next_state = lwc_pkg::LWC_ST_RUN;
				end else begin
					next_settle_cnt = settle_cnt + 3'h1;
				end
			end
			lwc_pkg::LWC_ST_RUN: begin
				next_state = lwc_pkg::LWC_ST_RUN;
			end
			default: begin
				next_state = lwc_pkg::LWC_ST_SETTLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state <= lwc_pkg::LWC_ST_SETTLE;
			settle_cnt <= 3'h0;
			contender_default <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			settle_cnt <= next_settle_cnt;
			contender_default <= next_contender_default;
		end
	end

	// power status low-time filter
	always_comb begin
		if (pwr_sync) begin
			next_pwr_low_cnt = 6'h0;
		end else if (pwr_low_cnt <= lwc_pkg::PWR_LOW_LIMIT) begin
			next_pwr_low_cnt = pwr_low_cnt + 6'h1; // saturates one past the limit
		end else begin
			next_pwr_low_cnt = pwr_low_cnt;
		end
	end

	assign pwr_active = (pwr_low_cnt <= lwc_pkg::PWR_LOW_LIMIT);
	assign link_idle = !pwr_active || !ctrl[lwc_pkg::CTRL_LINK_ACT_BIT];
	// interrupt conditions that call for wake
	assign irq_cond = irq_stat[lwc_pkg::IRQ_PORT_EV_BIT] ||
		(ctrl[lwc_pkg::CTRL_RESUME_EN_BIT] && (irq_stat[lwc_pkg::IRQ_CFG_TO_BIT] ||
		irq_stat[lwc_pkg::IRQ_CBL_PWR_BIT] || irq_stat[lwc_pkg::IRQ_STATE_TO_BIT]));

	// wake decision and square wave, nothing wakes before the strap is taken
	always_comb begin
		next_linkon_pending = linkon_pending;
		next_wake_active = wake_active;
		if (state != lwc_pkg::LWC_ST_RUN || !link_idle) begin
			next_linkon_pending = 1'b0;
			next_wake_active = 1'b0;
		end else if (bus_reset) begin
			next_linkon_pending = 1'b0;
			next_wake_active = irq_cond;
		end else begin
			next_linkon_pending = linkon_pending || link_on_packet_rx;
			// latched: clearing the cause does not stop it while the link is idle
			next_wake_active = wake_active || next_linkon_pending || irq_cond;
		end
		next_phase_cnt = 2'h0;
		next_wave = 1'b0;
		if (wake_active) begin
			next_phase_cnt = phase_cnt + 2'h1;
			next_wave = (phase_cnt == lwc_pkg::WAKE_HALF_LAST) ? !wave : wave;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_low_cnt <= 6'h0;
			linkon_pending <= 1'b0;
			wake_active <= 1'b0;
			phase_cnt <= 2'h0;
			wave <= 1'b0;
		end else if (ce) begin
			pwr_low_cnt <= next_pwr_low_cnt;
			linkon_pending <= next_linkon_pending;
			wake_active <= next_wake_active;
			phase_cnt <= next_phase_cnt;
			wave <= next_wave;
		end
	end

	// pin released in reset and until the strap is taken
	assign contender_strap_wake_pin_oe = (state == lwc_pkg::LWC_ST_RUN);
	assign contender_strap_wake_pin_out = wave;

	// ahb-lite slave, zero wait states, always okay
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign addr_phase = hsel && htrans[1] && hready;

	assign stat_word = {27'h0, linkon_pending, wake_active, link_idle, pwr_active,
		contender_default};

	// address phase capture, read data and register updates
	always_comb begin
		next_dp_write = addr_phase && hwrite;
		next_dp_addr = haddr[3:0];
		next_hrdata = hrdata;
		if (addr_phase && !hwrite) begin
			case (haddr[3:0])
				lwc_pkg::OFF_LINK_CTRL: next_hrdata = {30'h0, ctrl};
				lwc_pkg::OFF_IRQ_STAT: next_hrdata = {28'h0, irq_stat};
				lwc_pkg::OFF_WAKE_STAT: next_hrdata = stat_word;
				default: next_hrdata = 32'h0;
			endcase
		end
		next_ctrl = ctrl;
		next_irq_stat = irq_stat;
		if (dp_write && dp_addr == lwc_pkg::OFF_LINK_CTRL) begin
			next_ctrl = hwdata[1:0];
		end
		if (dp_write && dp_addr == lwc_pkg::OFF_IRQ_STAT) begin
			next_irq_stat = irq_stat & ~hwdata[3:0]; // write one to clear
		end
		next_irq_stat = next_irq_stat | irq_events; // set wins over clear
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_write <= 1'b0;
			dp_addr <= 4'h0;
			hrdata <= 32'h0;
			ctrl <= lwc_pkg::CTRL_RESET;
			irq_stat <= lwc_pkg::IRQ_RESET;
		end else if (ce) begin
			dp_write <= next_dp_write;
			dp_addr <= next_dp_addr;
			hrdata <= next_hrdata;
			ctrl <= next_ctrl;
			irq_stat <= next_irq_stat;
		end
	end
endmodule
`default_nettype wire

/* verilog/lwc_pkg.sv */
// package: constants and types for the link wake and contender strap block
`default_nettype none
package lwc_pkg;
	// clock rate and timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int PWR_LOW_NS = 2600;
	// least time: round up, at least one cycle
	localparam int PWR_LOW_RAW = (PWR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PWR_LOW_CYC = (PWR_LOW_RAW < 1) ? 1 : PWR_LOW_RAW;
	localparam logic [5:0] PWR_LOW_LIMIT = 6'(PWR_LOW_CYC);
	// wake wave: period of eight clocks, toggle every half period
	localparam int WAKE_PERIOD_CYC = 8;
	localparam logic [1:0] WAKE_HALF_LAST = 2'(WAKE_PERIOD_CYC / 2 - 1);
	// edges after reset release before the strap level is taken
	localparam logic [2:0] STRAP_SETTLE = 3'h4;
	// register byte offsets
	localparam logic [3:0] OFF_LINK_CTRL = 4'h0;
	localparam logic [3:0] OFF_IRQ_STAT = 4'h4;
	localparam logic [3:0] OFF_WAKE_STAT = 4'h8;
	// link control fields
	localparam int CTRL_LINK_ACT_BIT = 0;
	localparam int CTRL_RESUME_EN_BIT = 1;
	localparam logic [1:0] CTRL_RESET = 2'h0;
	// interrupt status fields
	localparam int IRQ_PORT_EV_BIT = 0;
	localparam int IRQ_CFG_TO_BIT = 1;
	localparam int IRQ_CBL_PWR_BIT = 2;
	localparam int IRQ_STATE_TO_BIT = 3;
	localparam logic [3:0] IRQ_RESET = 4'h0;
	// wake status fields
	localparam int STAT_CONTENDER_BIT = 0;
	localparam int STAT_PWR_ACTIVE_BIT = 1;
	localparam int STAT_LINK_IDLE_BIT = 2;
	localparam int STAT_WAKE_BIT = 3;
	localparam int STAT_LINKON_BIT = 4;
	// interrupt event pulses from the rest of the phy
	typedef struct packed {
		logic state_to;
		logic cable_pwr;
		logic cfg_to;
		logic port_ev;
	} lwc_irq_ev_t;
	// strap and wake bookkeeping
	typedef enum logic [1:0] {
		LWC_ST_SETTLE = 2'b00,
		LWC_ST_RUN = 2'b01
	} lwc_state_t;
endpackage
`default_nettype wire

/* verilog/lwc_sync3.sv */
// module: three-stage input synchroniser with agreement filter
`default_nettype none
module lwc_sync3 #(
	parameter int WIDTH = 1
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic ce,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;
	logic [WIDTH-1:0] next_sync_out;

	// take a new level only where stages two and three agree
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			next_sync_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
		end
	end

	// shift chain
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
			sync_out <= '0;
		end else if (ce) begin
			stage1 <= async_in;
			stage2 <= stage1;
			stage3 <= stage2;
			sync_out <= next_sync_out;
		end
	end
endmodule
`default_nettype wire

/* tb/lwc_chk.sv */
// checker: assertions on the strap pin, wake wave and bus answer
`default_nettype none
module lwc_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic contender_strap_wake_pin_in,
	input wire logic contender_strap_wake_pin_out,
	input wire logic contender_strap_wake_pin_oe,
	input wire logic contender_default
);
	timeunit 1ns;
	timeprecision 1ns;
	// short aliases for the pin signals
	wire oe = contender_strap_wake_pin_oe;
	wire out = contender_strap_wake_pin_out;
	wire pin = contender_strap_wake_pin_in;
	wire cdef = contender_default;
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// strap capture, then the pin is driven for good
	chk_strap_float: assert property ($rose(hresetn) |-> !oe [*4])
		else $error("pin driven in strap window");
	chk_pin_driven: assert property (oe |=> oe)
		else $error("pin released after strap");
	chk_strap_take: assert property ($rose(oe) |-> cdef == $past(pin, 2))
		else $error("contender not taken from strap");
	chk_strap_hold: assert property (oe |=> $stable(cdef))
		else $error("contender changed after strap");
	// wave shape: at most four high, at least four low
	chk_idle_low: assert property (!oe |-> !out)
		else $error("wave level while undriven");
	chk_high_len: assert property (out [*4] |=> !out)
		else $error("wave high too long");
	chk_low_len: assert property ($fell(out) |-> !out [*4])
		else $error("wave low too short");
	chk_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	cover property ($rose(oe));
	cover property ($rose(out));
	cover property (out [*4] ##1 !out [*4]);
endmodule
bind lwc_top lwc_chk u_chk (.hclk, .hresetn, .hreadyout, .hresp,
	.contender_strap_wake_pin_in, .contender_strap_wake_pin_out,
	.contender_strap_wake_pin_oe, .contender_default);
`default_nettype wire

/* tb/lwc_llc_model.sv */
// model: link controller that powers up when it sees the wake pin high
`default_nettype none
module lwc_llc_model (
	input wire logic hclk,
	input wire logic asleep,
	input wire logic pin,
	output logic link_power_status
);
	timeunit 1ns;
	timeprecision 1ns;
	logic woke = 1'h0;
	// a wake level seen while asleep brings power back
	always @(posedge hclk) woke <= asleep & (woke | pin);
	assign link_power_status = !asleep | woke;
endmodule
`default_nettype wire

/* tb/tb_link_wake_and_contender_strap.sv */
// testbench: strap capture, wake causes, wave shape and link power handshake
`default_nettype none
module tb_link_wake_and_contender_strap;
	timeunit 1ns;
	timeprecision 1ns;
	logic hclk, hresetn, ce, hsel, hwrite, lon, brst, asleep, strap;
	logic [31:0] haddr, hwdata, q;
	logic [1:0] htrans;
	logic [2:0] hsize;
	lwc_pkg::lwc_irq_ev_t ev;
	wire hready, hreadyout, hresp, pout, poe, cdef, pwr, pin;
	wire [31:0] hrdata;
	int n_errors = 0;
	int compares = 0;
	// pin level: driven wave or the strap resistor
	assign pin = poe ? pout : strap;
	assign hready = hreadyout;
	lwc_top u_dut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout, .hresp, .hrdata, .link_power_status(pwr),
		.link_on_packet_rx(lon), .bus_reset(brst), .irq_events(ev),
		.contender_strap_wake_pin_in(pin), .contender_strap_wake_pin_out(pout),
		.contender_strap_wake_pin_oe(poe), .contender_default(cdef));
	lwc_llc_model u_llc (.hclk, .asleep, .pin, .link_power_status(pwr));
	task automatic close_out();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			$display("BAD %s exp %h seen %h", nm, exp, seen);
			n_errors++;
		end
	endtask
	// one bus phase, ended by ready at an edge
	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'h1 && n < 20);
		if (hready !== 1'h1) begin
			n_errors++;
			close_out();
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		haddr <= {28'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		rdy();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		q = hrdata;
	endtask
	task automatic wk(input logic e);
		repeat (3) @(posedge hclk);
		bus(1'h0, 4'h8, 32'h0);
		chk("wake", q[3], e);
	endtask
	task automatic rise(output int n);
		n = 0;
		do begin
			@(posedge hclk);
			#1;
			n++;
		end while (pout !== 1'h1 && n < 80);
		if (pout !== 1'h1) begin
			n_errors++;
			close_out();
		end
	endtask
	task automatic wave();
		int n;
		logic [15:0] s;
		rise(n);
		s = 16'h1;
		repeat (15) begin
			@(posedge hclk);
			#1;
			s = {s[14:0], pout};
		end
		chk("wave", s, 16'hf0f0);
		@(posedge hclk);
	endtask
	task automatic t_strap(input logic s);
		strap <= s;
		hresetn <= 1'h0;
		repeat (10) @(posedge hclk);
		chk("oe_rst", poe, 1'h0);
		hresetn <= 1'h1;
		repeat (8) @(posedge hclk);
		chk("contender", cdef, s);
		chk("oe", poe, 1'h1);
		chk("out", pout, 1'h0);
		$display("strap test done");
	endtask
	task automatic t_linkon();
		lon <= 1'h1;
		@(posedge hclk);
		lon <= 1'h0;
		wave();
		wk(1'h1);
		brst <= 1'h1;
		@(posedge hclk);
		brst <= 1'h0;
		wk(1'h0);
		repeat (4) @(posedge hclk);
		chk("idle", pout, 1'h0);
		$display("link-on test done");
	endtask
	task automatic t_irq();
		for (int i = 0; i < 4; i++) begin
			ev <= lwc_pkg::lwc_irq_ev_t'(4'h1 << i);
			@(posedge hclk);
			ev <= 4'h0;
			wk(i == 0);
			bus(1'h1, 4'h0, 32'h2);
			brst <= 1'h1;
			@(posedge hclk);
			brst <= 1'h0;
			wk(1'h1);
			bus(1'h1, 4'h4, 32'h1 << i);
			wk(1'h1);
			bus(1'h1, 4'h0, 32'h1);
			bus(1'h1, 4'h0, 32'h0);
			wk(1'h0);
		end
		bus(1'h0, 4'hc, 32'h0);
		chk("unmapped", q, 32'h0);
		$display("irq test done");
	endtask
	task automatic t_active();
		int n;
		bus(1'h1, 4'h0, 32'h1);
		ev <= lwc_pkg::lwc_irq_ev_t'(4'h1);
		@(posedge hclk);
		ev <= 4'h0;
		wk(1'h0);
		asleep <= 1'h1;
		rise(n);
		chk("sleep_wait", n > 26, 1'h1);
		repeat (20) @(posedge hclk);
		wk(1'h0);
		chk("pin_off", pout, 1'h0);
		asleep <= 1'h0;
		bus(1'h1, 4'h4, 32'h1);
		bus(1'h1, 4'h0, 32'h0);
		$display("power test done");
	endtask
	// clock at 100 ns
	initial begin
		hclk = 1'h0;
		forever #50 hclk = ~hclk;
	end
	// main sequence, second strap run is a mid-run reset
	initial begin
		{hresetn, hsel, hwrite, lon, brst, asleep, strap} = 7'h0;
		{htrans, haddr, hwdata} = 66'h0;
		hsize = 3'h2;
		ce = 1'h1;
		ev = 4'h0;
		t_strap(1'h0);
		t_strap(1'h1);
		t_linkon();
		t_irq();
		t_active();
		close_out();
	end
endmodule
`default_nettype wire
